// [hdl/jtag_tap_chain_debug_port.sv]
// Purpose: Serial test-access chain of three TAPs with debug sync pin.
// Assumes: TCK, TMS, TDI and the debug pin are sampled by i_clk.
// Notes: TDO changes after a falling TCK edge, TAPs move on rising edges.
`timescale 1ns/1ps

module jtag_tap_chain_debug_port
  import jtag_debug_pkg::*;
#(
  parameter int BSR_W = jtag_debug_pkg::BSR_W_DEFAULT
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input jtag_debug_pkg::jtag_pins_type i_jtag,
  output logic o_tdo,
  output logic o_tdo_oe,
  input wire logic [jtag_debug_pkg::SEC_W-1:0] i_security,
  input wire logic [BSR_W-1:0] i_pin_in,
  output logic [BSR_W-1:0] o_pin_out,
  output logic o_pin_extest,
  input wire logic [jtag_debug_pkg::DR_W-1:0] i_periph_rdata,
  output jtag_debug_pkg::access_req_type o_periph,
  input wire logic [jtag_debug_pkg::DR_W-1:0] i_core_rdata,
  output jtag_debug_pkg::access_req_type o_core,
  input wire logic [jtag_debug_pkg::DR_W-1:0] i_otp_rdata,
  output jtag_debug_pkg::access_req_type o_otp,
  input jtag_debug_pkg::dbg_mode_type i_dbg_mode,
  input wire logic i_breakpoint,
  input wire logic i_dbg_release,
  input wire logic i_dbg_in,
  output logic o_dbg_out,
  output logic o_dbg_oe,
  output logic o_debug_enter
);
  import jtag_debug_pkg::*;

  typedef struct packed {
    logic [1:0] tck_sync;
    logic [1:0] tms_sync;
    logic [1:0] tdi_sync;
    logic [1:0] dbg_sync;
    logic tck_prev;
    logic dbg_prev;
    logic [TMS_CNT_W-1:0] tms_ones;
    tap_state_type [NUM_TAPS-1:0] tap;
    logic [NUM_TAPS-1:0][IR_W-1:0] ir;
    logic [NUM_TAPS-1:0][IR_W-1:0] ir_shift;
    logic [NUM_TAPS-1:0][DR_W-1:0] dr;
    logic tdo;
    logic tdo_oe;
    logic [BSR_W-1:0] pin_out;
    logic pin_extest;
    access_req_type periph;
    access_req_type core;
    access_req_type otp;
    logic dbg_out;
    logic dbg_oe;
    logic debug_enter;
  } state_type;

  state_type st;
  state_type next_st;

  localparam logic [DR_W-1:0] DEVICE_IDENTIFICATION_VALUE =
    {ID_VERSION, ID_PART, ID_MANUF, 1'b1};

  function automatic tap_state_type next_tap(input tap_state_type s,
                                             input logic tms);
    tap_state_type r;
    r = s;
    case (s)
      TLR: r = tms ? TLR : RTI;
      RTI: r = tms ? SEL_DR : RTI;
      SEL_DR: r = tms ? SEL_IR : CAP_DR;
      CAP_DR: r = tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: r = tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: r = tms ? UPD_DR : PAUSE_DR;
      PAUSE_DR: r = tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: r = tms ? UPD_DR : SHIFT_DR;
      UPD_DR: r = tms ? SEL_DR : RTI;
      SEL_IR: r = tms ? TLR : CAP_IR;
      CAP_IR: r = tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: r = tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: r = tms ? UPD_IR : PAUSE_IR;
      PAUSE_IR: r = tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: r = tms ? UPD_IR : SHIFT_IR;
      UPD_IR: r = tms ? SEL_DR : RTI;
      default: r = TLR;
    endcase
    return r;
  endfunction

  // Length of the data register that the given TAP and instruction select.
  function automatic int dr_len(input int tap_idx,
                                input logic [IR_W-1:0] ir);
    int len;
    len = 1;
    if (ir == IR_DEVICE_IDENTIFICATION || ir == IR_USERCODE)
    begin
      len = DR_W;
    end
    else if (tap_idx == TAP_BSCAN && (ir == IR_EXTEST || ir == IR_SAMPLE))
    begin
      len = BSR_W;
    end
    else if (ir == IR_ACCESS && tap_idx != TAP_BSCAN)
    begin
      len = DR_W;
    end
    else if (ir == IR_OTP && tap_idx == TAP_CORE)
    begin
      len = DR_W;
    end
    return len;
  endfunction

  // Shifts one bit in at position len-1, moving bits below toward bit 0.
  function automatic logic [DR_W-1:0] shift_in(input logic [DR_W-1:0] v,
                                               input logic b,
                                               input int len);
    logic [DR_W-1:0] r;
    r = v;
    for (int i = 0; i < DR_W; i++)
    begin
      if (i == len - 1)
      begin
        r[i] = b;
      end
      else if (i < len - 1)
      begin
        r[i] = v[i+1];
      end
    end
    return r;
  endfunction

  always_comb
  begin
    logic [NUM_TAPS-1:0] out_bit;
    logic in_bit;
    logic [NUM_TAPS-1:0] chain_in;
    logic rise;
    logic fall;
    logic tms;
    logic force_reset;
    logic otp_block;
    logic pin_off;
    logic [DR_W-1:0] usercode;
    out_bit = '0;
    in_bit = 1'b0;
    chain_in = '0;
    next_st = st;
    rise = st.tck_sync[1] & ~st.tck_prev;
    fall = ~st.tck_sync[1] & st.tck_prev;
    tms = st.tms_sync[1];
    force_reset = 1'b0;
    otp_block = i_security[SEC_OTP_OFF_BIT];
    pin_off = i_security[SEC_DEBUG_PIN_OFF_BIT];
    usercode = {i_security[UID_HI:UID_LO], {UNUSED_W{1'b0}},
                SILICON_REV};

    next_st.tck_sync = {st.tck_sync[0], i_jtag.tck};
    next_st.tms_sync = {st.tms_sync[0], i_jtag.tms};
    next_st.tdi_sync = {st.tdi_sync[0], i_jtag.tdi};
    next_st.dbg_sync = {st.dbg_sync[0], i_dbg_in};
    next_st.tck_prev = st.tck_sync[1];
    next_st.dbg_prev = st.dbg_sync[1];
    next_st.periph.wr = 1'b0;
    next_st.core.wr = 1'b0;
    next_st.otp.wr = 1'b0;
    next_st.debug_enter = 1'b0;
    next_st.dbg_out = 1'b0;

    for (int i = 0; i < NUM_TAPS; i++)
    begin
      if (st.tap[i] == SHIFT_IR)
      begin
        out_bit[i] = st.ir_shift[i][0];
      end
      else
      begin
        out_bit[i] = st.dr[i][0];
      end
    end

    chain_in = {out_bit[NUM_TAPS-2:0], st.tdi_sync[1]};
    if (rise)
    begin
      if (tms)
      begin
        if (st.tms_ones < TMS_RESET_COUNT)
        begin
          next_st.tms_ones = st.tms_ones + 3'h1;
        end
        force_reset = (st.tms_ones >= TMS_RESET_COUNT - 3'h1);
      end
      else
      begin
        next_st.tms_ones = '0;
      end
      for (int i = 0; i < NUM_TAPS; i++)
      begin
        in_bit = chain_in[i];
        next_st.tap[i] = force_reset ? TLR : next_tap(st.tap[i], tms);
        case (st.tap[i])
          TLR:
          begin
            next_st.ir[i] = IR_DEVICE_IDENTIFICATION;
          end
          CAP_IR:
          begin
            next_st.ir_shift[i] = IR_CAPTURE;
          end
          SHIFT_IR:
          begin
            next_st.ir_shift[i] = {in_bit, st.ir_shift[i][IR_W-1:1]};
          end
          UPD_IR:
          begin
            // The code takes effect here, never while it is half shifted.
            next_st.ir[i] = st.ir_shift[i];
          end
          CAP_DR:
          begin
            next_st.dr[i] = '0;
            if (st.ir[i] == IR_DEVICE_IDENTIFICATION)
            begin
              next_st.dr[i] = DEVICE_IDENTIFICATION_VALUE;
            end
            else if (st.ir[i] == IR_USERCODE)
            begin
              next_st.dr[i] = usercode;
            end
            else if (dr_len(i, st.ir[i]) == BSR_W && i == TAP_BSCAN)
            begin
              next_st.dr[i][BSR_W-1:0] = i_pin_in;
            end
            else if (i == TAP_DEBUG && st.ir[i] == IR_ACCESS)
            begin
              next_st.dr[i] = i_periph_rdata;
            end
            else if (i == TAP_CORE && st.ir[i] == IR_ACCESS)
            begin
              next_st.dr[i] = i_core_rdata;
            end
            else if (i == TAP_CORE && st.ir[i] == IR_OTP && !otp_block)
            begin
              next_st.dr[i] = i_otp_rdata;
            end
          end
          SHIFT_DR:
          begin
            next_st.dr[i] = shift_in(st.dr[i], in_bit,
                                     dr_len(i, st.ir[i]));
          end
          UPD_DR:
          begin
            if (i == TAP_BSCAN && st.ir[i] == IR_EXTEST)
            begin
              next_st.pin_out = st.dr[i][BSR_W-1:0];
            end
            if (i == TAP_DEBUG && st.ir[i] == IR_ACCESS)
            begin
              next_st.periph.wr = 1'b1;
              next_st.periph.data = st.dr[i];
            end
            if (i == TAP_CORE && st.ir[i] == IR_ACCESS)
            begin
              next_st.core.wr = 1'b1;
              next_st.core.data = st.dr[i];
            end
            if (i == TAP_CORE && st.ir[i] == IR_OTP && !otp_block)
            begin
              next_st.otp.wr = 1'b1;
              next_st.otp.data = st.dr[i];
            end
          end
          default:
          begin
          end
        endcase
      end
    end

    next_st.pin_extest = (st.ir[TAP_BSCAN] == IR_EXTEST) &&
                         (st.tap[TAP_BSCAN] != TLR);

    if (fall)
    begin
      next_st.tdo = out_bit[NUM_TAPS-1];
      next_st.tdo_oe = (st.tap[NUM_TAPS-1] == SHIFT_IR) ||
                       (st.tap[NUM_TAPS-1] == SHIFT_DR);
    end

    if (pin_off || i_dbg_mode != DBG_OUTPUT || i_dbg_release)
    begin
      next_st.dbg_oe = 1'b0;
    end
    if (!pin_off && i_dbg_mode == DBG_OUTPUT && i_breakpoint)
    begin
      next_st.dbg_oe = 1'b1;
    end
    if (!pin_off && i_dbg_mode == DBG_INPUT &&
        st.dbg_prev && !st.dbg_sync[1])
    begin
      next_st.debug_enter = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st <= '0;
      st.tck_sync <= 2'h0;
      st.tms_sync <= 2'h3;
      st.tdi_sync <= 2'h3;
      st.dbg_sync <= 2'h3;
      st.dbg_prev <= 1'b1;
      st.ir <= {NUM_TAPS{IR_DEVICE_IDENTIFICATION}};
      st.tap <= {NUM_TAPS{TLR}};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_tdo = st.tdo;
  assign o_tdo_oe = st.tdo_oe;
  assign o_pin_out = st.pin_out;
  assign o_pin_extest = st.pin_extest;
  assign o_periph = st.periph;
  assign o_core = st.core;
  assign o_otp = st.otp;
  assign o_dbg_out = st.dbg_out;
  assign o_dbg_oe = st.dbg_oe;
  assign o_debug_enter = st.debug_enter;

endmodule

// [hdl/jtag_debug_pkg.sv]
// Purpose: Shared constants, codes and carrier types for the test-access port.
// Assumes: One processing tile, so the scan chain holds three TAPs.
// Notes: Identification fields are arbitrary neutral values.
package jtag_debug_pkg;

  localparam int NUM_TAPS = 3;
  localparam int TAP_DEBUG = 0;
  localparam int TAP_BSCAN = 1;
  localparam int TAP_CORE = 2;
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam int BSR_W_DEFAULT = 16;
  localparam int REV_W = 8;
  localparam int UNUSED_W = 14;
  localparam int UID_HI = 31;
  localparam int UID_LO = 22;
  localparam int SEC_W = 32;
  localparam int SEC_OTP_OFF_BIT = 13;
  localparam int SEC_DEBUG_PIN_OFF_BIT = 14;
  localparam int TMS_CNT_W = 3;
  localparam logic [TMS_CNT_W-1:0] TMS_RESET_COUNT = 3'h5;

  localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] IR_DEVICE_IDENTIFICATION = 4'h1;
  localparam logic [IR_W-1:0] IR_USERCODE = 4'h2;
  localparam logic [IR_W-1:0] IR_SAMPLE = 4'h3;
  localparam logic [IR_W-1:0] IR_ACCESS = 4'h4;
  localparam logic [IR_W-1:0] IR_OTP = 4'h6;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  // Identification fields; values are arbitrary.
  localparam logic [3:0] ID_VERSION = 4'h0;
  localparam logic [15:0] ID_PART = 16'h0001;
  localparam logic [10:0] ID_MANUF = 11'h2A5;
  localparam logic [REV_W-1:0] SILICON_REV = 8'h01;

  typedef enum logic [3:0] {
    TLR = 4'h0,
    RTI = 4'h1,
    SEL_DR = 4'h3,
    CAP_DR = 4'h2,
    SHIFT_DR = 4'h6,
    EXIT1_DR = 4'h7,
    PAUSE_DR = 4'h5,
    EXIT2_DR = 4'h4,
    UPD_DR = 4'hC,
    SEL_IR = 4'hD,
    CAP_IR = 4'hF,
    SHIFT_IR = 4'hE,
    EXIT1_IR = 4'hA,
    PAUSE_IR = 4'hB,
    EXIT2_IR = 4'h9,
    UPD_IR = 4'h8
  } tap_state_type;

  typedef enum logic [1:0] {
    DBG_OFF = 2'h0,
    DBG_OUTPUT = 2'h1,
    DBG_INPUT = 2'h2
  } dbg_mode_type;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtag_pins_type;

  typedef struct packed {
    logic wr;
    logic [DR_W-1:0] data;
  } access_req_type;

endpackage

// [testbench/jtag_host.sv]
// Purpose: Scan host model that walks TCK, TMS and TDI from i_clk.
// Assumes: TCK high and low for four i_clk cycles each, 200 ns period.
// Notes: TCK stands low between frames; TDO is read mid high phase.
`timescale 1ns/1ps
module jtag_host
  import jtag_debug_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_tdo,
  output jtag_debug_pkg::jtag_pins_type o_jtag
);
  initial o_jtag = '0;
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // One TCK period; TDO is read well after the last falling edge.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_jtag.tms = tms;
    o_jtag.tdi = tdi;
    wait_clk(4);
    o_jtag.tck = 1'b1;
    wait_clk(2);
    tdo = i_tdo;
    wait_clk(2);
    o_jtag.tck = 1'b0;
  endtask
  task automatic reset5();
    logic b;
    repeat (5) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
  // From Run-Test-Idle through a shift and back to Run-Test-Idle.
  task automatic shift(input logic ir, input logic din[$],
                       output logic dout[$]);
    logic b;
    dout.delete();
    step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    foreach (din[i])
    begin
      step(i == din.size() - 1, din[i], b);
      dout.push_back(b);
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
endmodule

// [testbench/jtag_properties.sv]
// Purpose: Port checks for the test-access chain and debug pin.
// Assumes: One clock, synchronous active-high reset.
// Notes: TCK edges are found by resampling the pin.
`timescale 1ns/1ps
module jtag_properties
  import jtag_debug_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input jtag_debug_pkg::jtag_pins_type i_jtag,
  input wire logic o_tdo_oe,
  input wire logic [jtag_debug_pkg::SEC_W-1:0] i_security,
  input wire logic o_pin_extest,
  input jtag_debug_pkg::access_req_type o_otp,
  input jtag_debug_pkg::dbg_mode_type i_dbg_mode,
  input wire logic i_breakpoint,
  input wire logic i_dbg_release,
  input wire logic i_dbg_in,
  input wire logic o_dbg_out,
  input wire logic o_dbg_oe,
  input wire logic o_debug_enter
);
  logic [2:0] tck_d;
  logic [2:0] ones;
  wire logic kill = i_security[SEC_DEBUG_PIN_OFF_BIT];
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  always_ff @(posedge i_clk)
  begin
    tck_d <= {tck_d[1:0], i_jtag.tck};
    if (i_rst)
      ones <= 3'h0;
    else if (tck_d[1] && !tck_d[2])
      ones <= !i_jtag.tms ? 3'h0 : ones + 3'(ones != 3'h5);
  end
  tap_reset_a: assert property (ones == 3'h5 |-> ##[0:6]
    !o_tdo_oe && !o_pin_extest) else $error("chain not reset");
  bkpt_drive_a: assert property (i_breakpoint && !kill
    && i_dbg_mode == DBG_OUTPUT |=> o_dbg_oe) else $error("pin not driven");
  drive_low_a: assert property (o_dbg_oe |-> !o_dbg_out)
    else $error("pin driven high");
  float_until_a: assert property ($rose(o_dbg_oe) |->
    $past(i_breakpoint)) else $error("pin driven early");
  release_pin_a: assert property (i_dbg_release && !i_breakpoint |=>
    !o_dbg_oe) else $error("pin not released");
  pin_off_a: assert property (kill [*4] |=> !o_dbg_oe && !o_debug_enter)
    else $error("pin not disabled");
  enter_cause_a: assert property ($fell(i_dbg_in) && !kill
    && i_dbg_mode == DBG_INPUT |-> ##[1:5] o_debug_enter)
    else $error("debug entry missing");
  enter_pulse_a: assert property (o_debug_enter |=> !o_debug_enter)
    else $error("debug entry too long");
  otp_block_a: assert property (i_security[SEC_OTP_OFF_BIT] |=>
    !o_otp.wr) else $error("otp write not blocked");
  cover property ($rose(o_dbg_oe));
  cover property (o_debug_enter);
  cover property (ones == 3'h5);
endmodule
bind jtag_tap_chain_debug_port jtag_properties u_props (.i_clk(i_clk),
  .i_rst(i_rst), .i_jtag(i_jtag), .o_tdo_oe(o_tdo_oe),
  .i_security(i_security), .o_pin_extest(o_pin_extest), .o_otp(o_otp),
  .i_dbg_mode(i_dbg_mode), .i_breakpoint(i_breakpoint),
  .i_dbg_release(i_dbg_release), .i_dbg_in(i_dbg_in),
  .o_dbg_out(o_dbg_out), .o_dbg_oe(o_dbg_oe),
  .o_debug_enter(o_debug_enter));

// [testbench/test_jtag_tap_chain_debug_port.sv]
// Purpose: Self-checking bench for the scan chain and debug pin.
// Assumes: Host model drives the link; inputs change 1 ns after edges.
// Notes: Expected scan bits are built in queues from constants and the driven inputs.
`timescale 1ns/1ps
module test_jtag_tap_chain_debug_port;
  import jtag_debug_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  jtag_pins_type jtag;
  logic tdo, tdo_oe, extest, dbg_out, dbg_oe, enter;
  logic [SEC_W-1:0] sec = '0;
  logic [BSR_W_DEFAULT-1:0] pin_in = '0, pin_out;
  logic [DR_W-1:0] p_rd = '0, c_rd = '0, o_rd = '0, p_dat, o_dat, c_dat, w;
  access_req_type periph, core, otp;
  dbg_mode_type mode = DBG_OFF;
  logic bkpt = 1'b0, rel = 1'b0, dbg_in = 1'b1;
  int err_count = 0, checked = 0, cycles = 0, seed = 19783;
  int n_p = 0, n_o = 0, n_e = 0, n_c = 0;
  logic q_in[$], q_out[$], q_exp[$];
  jtag_host host (.i_clk(i_clk), .i_tdo(tdo_oe ? tdo : ~tdo), .o_jtag(jtag));
  jtag_tap_chain_debug_port DUT (.i_clk(i_clk), .i_rst(i_rst),
    .i_jtag(jtag), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_security(sec),
    .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_extest(extest),
    .i_periph_rdata(p_rd), .o_periph(periph), .i_core_rdata(c_rd),
    .o_core(core), .i_otp_rdata(o_rd), .o_otp(otp), .i_dbg_mode(mode),
    .i_breakpoint(bkpt), .i_dbg_release(rel), .i_dbg_in(dbg_in),
    .o_dbg_out(dbg_out), .o_dbg_oe(dbg_oe), .o_debug_enter(enter));
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cycles++;
    if (periph.wr === 1'b1) p_dat = periph.data;
    if (otp.wr === 1'b1) o_dat = otp.data;
    if (core.wr === 1'b1) c_dat = core.data;
    n_c += int'(core.wr === 1'b1);
    n_p += int'(periph.wr === 1'b1);
    n_o += int'(otp.wr === 1'b1);
    n_e += int'(enter === 1'b1);
    if (cycles == 10000)
    begin
      err_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [DR_W-1:0] seen, input logic [DR_W-1:0] e);
    checked++;
    if (seen !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic put(input logic [DR_W-1:0] v);
    for (int j = 0; j < DR_W; j++) q_exp.push_back(v[j]);
  endtask
  task automatic scan(input logic ir, input int n);
    logic [DR_W-1:0] s, e;
    while (q_in.size() < n) q_in.push_back(1'($random(seed)));
    host.shift(ir, q_in, q_out);
    for (int i = 0; i < n; i++)
    begin
      if (i % DR_W == 0) {s, e} = '0;
      s[i % DR_W] = q_out[i];
      e[i % DR_W] = q_exp[i];
      if (i % DR_W == DR_W - 1 || i == n - 1) check(s, e);
    end
    q_exp.delete();
  endtask
  task automatic ir_load(input logic [IR_W-1:0] d, b, c);
    logic [3*IR_W-1:0] v;
    v = {d, b, c};
    q_in.delete();
    for (int j = 0; j < 3 * IR_W; j++)
    begin
      q_in.push_back(v[j]);
      q_exp.push_back(IR_CAPTURE[j % IR_W]);
    end
    scan(1'b1, 3 * IR_W);
  endtask
  initial
  begin
    tick(2);
    i_rst = 1'b0;
    tick(3);
    check(32'(dbg_oe), 32'h0);
    host.reset5();
    repeat (3) put({ID_VERSION, ID_PART, ID_MANUF, 1'b1});
    scan(1'b0, 3 * DR_W);
    for (int k = 0; k < 2; k++)
    begin
      sec = k ? 32'($random(seed)) : 32'h0;
      ir_load(IR_USERCODE, IR_USERCODE, IR_USERCODE);
      repeat (3) put({sec[UID_HI:UID_LO], 14'h0, SILICON_REV});
      scan(1'b0, 3 * DR_W);
    end
    for (int k = 0; k < 3; k++)
    begin
      sec[SEC_OTP_OFF_BIT] = k[0];
      p_rd = $random(seed);
      o_rd = $random(seed);
      c_rd = $random(seed);
      ir_load(IR_ACCESS, IR_BYPASS, k == 2 ? IR_ACCESS : IR_OTP);
      put(k == 2 ? c_rd : k ? 32'h0 : o_rd);
      q_exp.push_back(1'b0);
      put(p_rd);
      n_p = 0;
      n_o = 0;
      n_c = 0;
      q_in.delete();
      scan(1'b0, 2 * DR_W + 1);
      for (int j = 0; j < DR_W; j++) w[j] = q_in[DR_W + 1 + j];
      check(p_dat, w);
      check(32'(n_p + 2 * n_o + 4 * n_c),
            k == 2 ? 32'h5 : (k ? 32'h1 : 32'h3));
      for (int j = 0; j < DR_W; j++) w[j] = q_in[j];
      if (k != 1) check(k == 2 ? c_dat : o_dat, w);
    end
    pin_in = BSR_W_DEFAULT'($random(seed));
    for (int k = 0; k < 2; k++)
    begin
      ir_load(IR_BYPASS, k ? IR_EXTEST : IR_SAMPLE, IR_BYPASS);
      check(32'(extest), 32'(k));
      q_exp.push_back(1'b0);
      for (int j = 0; j < BSR_W_DEFAULT; j++) q_exp.push_back(pin_in[j]);
      q_exp.push_back(1'b0);
      q_in.delete();
      scan(1'b0, BSR_W_DEFAULT + 2);
    end
    for (int j = 0; j < BSR_W_DEFAULT; j++) w[j] = q_in[j + 1];
    check(32'(pin_out), 32'(w[BSR_W_DEFAULT-1:0]));
    host.reset5();
    check(32'(extest), 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      mode = dbg_mode_type'(k % 3);
      sec[SEC_DEBUG_PIN_OFF_BIT] = (k >= 3);
      n_e = 0;
      tick(4);
      bkpt = 1'b1;
      tick(1);
      bkpt = 1'b0;
      check(32'(dbg_oe), 32'(k == 1));
      tick(3);
      check(32'({dbg_oe, dbg_out}), k == 1 ? 32'h2 : 32'h0);
      rel = 1'b1;
      tick(1);
      rel = 1'b0;
      tick(1);
      check(32'(dbg_oe), 32'h0);
      dbg_in = 1'b0;
      tick(6);
      dbg_in = 1'b1;
      tick(4);
      check(32'(n_e), 32'(k == 2));
    end
    test_done();
  end
endmodule
